// ---- lcm_cell_reg.v ----
`timescale 1ns/1ps
module lcm_cell_reg (
  input wire sys_clk,
  input wire resetn,
  input wire clr_n,
  input wire pre_n,
  input wire clk_en,
  input wire d,
  output reg cell_q
);
  // clear wins over preset; both come from synchronised flops, so no glitches
  always @(posedge sys_clk or negedge resetn or negedge clr_n or negedge pre_n) begin
    if (!resetn) begin
      cell_q <= 1'b0;
    end else if (!clr_n) begin
      cell_q <= 1'b0;
    end else if (!pre_n) begin
      cell_q <= 1'b1;
    end else if (clk_en) begin
      cell_q <= d;
    end
  end
endmodule // lcm_cell_reg

// ---- lcm_checker.sv ----
`timescale 1ns/1ps
module lcm_checker (
  input wire sys_clk,
  input wire resetn,
  input wire [5:0] addr,
  input wire [31:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  input wire [31:0] rdata_q,
  input wire [7:0] cell_output,
  input wire carry_out,
  input wire cascade_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_wr_cfg;
    wr_stb && addr < 6'h20 && addr[1:0] == 2'h0;
  endsequence
  sequence s_rd_same;
    rd_stb && addr == $past(addr);
  endsequence
  a_rdata_idle: assert property (!rd_stb |=> rdata_q == 32'h00000000)
    else $error("read data not cleared");
  a_bad_addr: assert property (rd_stb && (addr[1:0] != 2'h0 || addr > 6'h2C)
    |=> rdata_q == 32'h00000000) else $error("unmapped read not zero");
  a_cfg_readback: assert property (s_wr_cfg ##1 s_rd_same
    |=> rdata_q == ($past(wdata, 2) & 32'h007FFFFF)) else $error("config readback");
  a_chain_readback: assert property (wr_stb && addr == 6'h28 ##1 s_rd_same
    |=> rdata_q == ($past(wdata, 2) & 32'h00000007)) else $error("chain readback");
  a_out_mirror: assert property (rd_stb && addr == 6'h24
    |=> rdata_q[7:0] == $past(cell_output)) else $error("cell output status");
  a_link_mirror: assert property (rd_stb && addr == 6'h24
    |=> rdata_q[17:16] == {$past(cascade_out), $past(carry_out)}) else $error("link status");
  a_q_upper: assert property (rd_stb && addr == 6'h20
    |=> rdata_q[31:8] == 24'h000000) else $error("register status upper bits");
  a_modes_upper: assert property (rd_stb && addr == 6'h2C
    |=> rdata_q[31:16] == 16'h0000) else $error("mode status upper bits");
endmodule // lcm_checker
bind lcm_group lcm_checker u_chk (.sys_clk, .resetn, .addr, .wdata, .wr_stb, .rd_stb,
  .rdata_q, .cell_output, .carry_out, .cascade_out);

// ---- lcm_defines.vh ----
`ifndef LCM_DEFINES_VH
`define LCM_DEFINES_VH

// register bus geometry
`define LCM_ADDR_W 6
`define LCM_DATA_W 32
`define LCM_CELLS 8
`define LCM_CELL_DIN 4

// byte offsets
`define LCM_OFS_CFG0 6'h00
`define LCM_OFS_STATUS_Q 6'h20
`define LCM_OFS_STATUS_OUT 6'h24
`define LCM_OFS_CHAIN 6'h28
`define LCM_OFS_MODES 6'h2C

// per-cell configuration word
`define LCM_CFG_W 23
`define LCM_CFG_LUT_HI 15
`define LCM_CFG_LUT_LO 0
`define LCM_CFG_MODE_HI 17
`define LCM_CFG_MODE_LO 16
`define LCM_CFG_CARRY_SEL 18
`define LCM_CFG_OUT_REG 19
`define LCM_CFG_CASC_EN 20
`define LCM_CFG_CLR_USE 21
`define LCM_CFG_PRE_USE 22
`define LCM_CFG_RST 23'h000000

// chain control word
`define LCM_CHAIN_W 3
`define LCM_CHAIN_CASC_EXT 0
`define LCM_CHAIN_CARRY_EXT 1
`define LCM_CHAIN_CARRY_VAL 2
`define LCM_CHAIN_RST 3'h3

// operating modes
`define LCM_MODE_NORMAL 2'h0
`define LCM_MODE_ARITH 2'h1
`define LCM_MODE_UPDN 2'h2
`define LCM_MODE_CLRCNT 2'h3

// pin synchroniser width and reset value: pre_n, clr_n, clk_en, data
`define LCM_SYNC_W 35
`define LCM_SYNC_RST 35'h600000000

`endif

// ---- lcm_group.v ----
`timescale 1ns/1ps
`include "lcm_defines.vh"

module lcm_group (
  input wire sys_clk,
  input wire resetn,
  input wire [5:0] addr,
  input wire [31:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [31:0] rdata_q,
  input wire [31:0] cell_data,
  input wire cell_clk_en,
  input wire cell_clr_n,
  input wire cell_pre_n,
  input wire carry_in,
  input wire cascade_in,
  output wire [7:0] cell_output,
  output wire carry_out,
  output wire cascade_out
);

  // table lookups: lut4 serves normal mode only, lut3 the other three modes
  function lut3;
    input [7:0] tbl;
    input [2:0] sel;
    begin
      lut3 = tbl[sel];
    end
  endfunction

  function lut4;
    input [15:0] tbl;
    input [3:0] sel;
    begin
      lut4 = tbl[sel];
    end
  endfunction

  // word-aligned address match, used by write and read decode
  function hit;
    input [5:0] a;
    input [5:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  function cfg_hit;
    input [5:0] a;
    begin
      cfg_hit = (a[5] == 1'b0) && (a[1:0] == 2'b00);
    end
  endfunction

  // configuration storage
  reg [22:0] cfg_q [0:7];
  reg [2:0] chain_q;
  integer k;

  // synchronised pins
  wire [34:0] sync_w;
  wire [31:0] dat_s;
  wire clk_en_s;
  wire clr_n_s;
  wire pre_n_s;

  // intra-group chains; index 8 leaves the group
  wire [8:0] carry_c;
  wire [8:0] casc_c;
  wire [7:0] q_w;
  wire [7:0] comb_w;
  wire [15:0] modes_w;

  lcm_sync #(
    .WIDTH(`LCM_SYNC_W),
    .RST_VAL(`LCM_SYNC_RST)
  ) u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .din({cell_pre_n, cell_clr_n, cell_clk_en, cell_data}),
    .dout_q(sync_w)
  );

  assign dat_s = sync_w[31:0];
  assign clk_en_s = sync_w[32];
  assign clr_n_s = sync_w[33];
  assign pre_n_s = sync_w[34];

  // configuration writes
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (k = 0; k < `LCM_CELLS; k = k + 1) begin
        cfg_q[k] <= `LCM_CFG_RST;
      end
      chain_q <= `LCM_CHAIN_RST;
    end else if (wr_stb) begin
      if (cfg_hit(addr)) begin
        cfg_q[addr[4:2]] <= wdata[22:0];
      end else if (hit(addr, `LCM_OFS_CHAIN)) begin
        chain_q <= wdata[2:0];
      end
    end
  end

  // chain entry: a group may continue the previous group or start fresh
  assign casc_c[0] = chain_q[`LCM_CHAIN_CASC_EXT] ? cascade_in : 1'b1;
  assign carry_c[0] = chain_q[`LCM_CHAIN_CARRY_EXT] ? carry_in :
                      chain_q[`LCM_CHAIN_CARRY_VAL];

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_cell
      wire [22:0] cfg;
      wire [3:0] d;
      wire [15:0] tbl;
      wire [1:0] mode;
      wire cin;
      wire casc;
      wire q;
      wire reg_clr_n;
      wire reg_pre_n;
      reg nxt;
      reg comb;
      reg cout;
      reg cascout;
      reg cnt;
      reg ld;

      assign cfg = cfg_q[i];
      // shared local interconnect slice for this cell
      assign d = dat_s[4*i+3:4*i];
      assign tbl = cfg[`LCM_CFG_LUT_HI:`LCM_CFG_LUT_LO];
      assign mode = cfg[`LCM_CFG_MODE_HI:`LCM_CFG_MODE_LO];
      assign cin = carry_c[i];
      assign casc = casc_c[i];
      assign q = q_w[i];

      // unused controls tie high so they never disturb the register
      assign reg_clr_n = cfg[`LCM_CFG_CLR_USE] ? clr_n_s : 1'b1;
      assign reg_pre_n = cfg[`LCM_CFG_PRE_USE] ? pre_n_s : 1'b1;

      always @* begin
        nxt = 1'b0;
        comb = 1'b0;
        cout = 1'b0;
        cascout = 1'b0;
        cnt = 1'b0;
        ld = 1'b0;
        case (mode)
          `LCM_MODE_NORMAL: begin
            comb = lut4(tbl, {cfg[`LCM_CFG_CARRY_SEL] ? cin : d[3], d[2:0]});
            if (cfg[`LCM_CFG_CASC_EN]) begin
              comb = comb & casc;
            end
            cascout = comb;
            nxt = comb;
          end
          `LCM_MODE_ARITH: begin
            cnt = lut3(tbl[7:0], {cin, d[1], d[0]});
            cout = lut3(tbl[15:8], {cin, d[1], d[0]});
            nxt = cnt;
            comb = cfg[`LCM_CFG_CASC_EN] ? (cnt & casc) : cnt;
            cascout = comb;
          end
          `LCM_MODE_UPDN: begin
            // d1 steers direction inside the tables, d2 enables, d3 loads d0
            cnt = lut3(tbl[7:0], {cin, d[1], q});
            cout = lut3(tbl[15:8], {cin, d[1], q});
            ld = d[3] ? d[0] : cnt;
            nxt = (d[3] || d[2]) ? ld : q;
            comb = cnt;
            cascout = casc;
          end
          `LCM_MODE_CLRCNT: begin
            // d1 becomes the active-low synchronous clear
            cnt = lut3(tbl[7:0], {cin, d[2], q});
            cout = lut3(tbl[15:8], {cin, d[2], q});
            ld = d[3] ? d[0] : cnt;
            nxt = ld & d[1];
            comb = cnt;
            cascout = casc;
          end
          default: begin
            nxt = 1'b0;
          end
        endcase
      end

      assign carry_c[i+1] = cout;
      assign casc_c[i+1] = cascout;
      assign comb_w[i] = comb;
      assign modes_w[2*i+1:2*i] = mode;
      // registered q when LCM_CFG_OUT_REG is set, else comb; the chains never see this mux
      assign cell_output[i] = cfg[`LCM_CFG_OUT_REG] ? q : comb;

      lcm_cell_reg u_reg (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .clr_n(reg_clr_n),
        .pre_n(reg_pre_n),
        .clk_en(clk_en_s),
        .d(nxt),
        .cell_q(q_w[i])
      );
    end
  endgenerate

  // last cell leaves the group toward the next group's first cell
  assign carry_out = carry_c[8];
  assign cascade_out = casc_c[8];

  // read data valid only in the cycle after the strobe
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 32'h00000000;
    end else if (!rd_stb) begin
      rdata_q <= 32'h00000000;
    end else if (cfg_hit(addr)) begin
      rdata_q <= {9'h000, cfg_q[addr[4:2]]};
    end else if (hit(addr, `LCM_OFS_STATUS_Q)) begin
      rdata_q <= {24'h000000, q_w};
    end else if (hit(addr, `LCM_OFS_STATUS_OUT)) begin
      rdata_q <= {14'h0000, casc_c[8], carry_c[8], comb_w, cell_output};
    end else if (hit(addr, `LCM_OFS_CHAIN)) begin
      rdata_q <= {29'h00000000, chain_q};
    end else if (hit(addr, `LCM_OFS_MODES)) begin
      rdata_q <= {16'h0000, modes_w};
    end else begin
      rdata_q <= 32'h00000000;
    end
  end

endmodule // lcm_group

// ---- lcm_group_tb.sv ----
`timescale 1ns/1ps
module lcm_group_tb;
  reg sys_clk, resetn, wr_stb, rd_stb, clk_en, clr_n, pre_n, n_cin, n_cas;
  reg [5:0] addr;
  reg [31:0] wdata, n_data, r, d;
  reg [15:0] lut;
  reg [8:0] x;
  reg [7:0] a, b, v, e;
  integer i, k, mismatches, checks_done, cyc;
  wire [31:0] rdata_q, cell_data;
  wire [7:0] cell_output;
  wire carry_in, cascade_in, carry_out, cascade_out;
  always #2.5 sys_clk = ~sys_clk;
  lcm_nbr nbr (.sys_clk, .req_data(n_data), .req_cin(n_cin), .req_cas(n_cas), .cell_data,
    .carry_in, .cascade_in);
  lcm_group dut (.sys_clk, .resetn, .addr, .wdata, .wr_stb, .rd_stb, .rdata_q, .cell_data,
    .cell_clk_en(clk_en), .cell_clr_n(clr_n), .cell_pre_n(pre_n), .carry_in, .cascade_in,
    .cell_output, .carry_out, .cascade_out);
  function [31:0] cfg(input [1:0] m, input [15:0] l, input [4:0] f);
    cfg = {9'h000, f, m, l};
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // a write is always read back at once, so back-to-back strobes get exercised
  task acc(input w, input [5:0] ad, input [31:0] wd);
    begin
      @(posedge sys_clk);
      addr <= ad;
      wdata <= wd;
      wr_stb <= w;
      rd_stb <= !w;
      @(posedge sys_clk);
      wr_stb <= 1'b0;
      rd_stb <= w;
      if (w) begin
        @(posedge sys_clk);
        rd_stb <= 1'b0;
      end
      @(negedge sys_clk);
      r = rdata_q;
    end
  endtask
  task setall(input [31:0] c);
    for (i = 0; i < 8; i = i + 1) begin
      acc(1'b1, {i[3:0], 2'h0}, c);
      chk(r, c & 32'h007FFFFF);
    end
  endtask
  // neighbour register plus two sync flops, with margin
  task drv(input [31:0] dd, input c, input s);
    begin
      n_data <= dd;
      n_cin <= c;
      n_cas <= s;
      repeat (6) @(posedge sys_clk);
      @(negedge sys_clk);
    end
  endtask
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc > 20000) begin
      mismatches = mismatches + 1;
      summarize;
    end
  end
  initial begin
    sys_clk = 1'b0;
    resetn = 1'b0;
    {wr_stb, rd_stb, clk_en, n_cin, n_cas} = 5'h00;
    {clr_n, pre_n} = 2'h3;
    addr = 6'h00;
    wdata = 32'h00000000;
    n_data = 32'h00000000;
    mismatches = 0;
    checks_done = 0;
    cyc = 0;
    i = $urandom(64872);
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    acc(1'b0, 6'h31, 32'h00000000);
    chk(r, 32'h00000000);
    acc(1'b0, 6'h28, 32'h00000000);
    chk(r, 32'h00000003);
    for (k = 0; k < 8; k = k + 1) begin
      lut = $urandom;
      setall(cfg(2'h0, lut, {4'h0, k[0]}));
      d = $urandom;
      drv(d, k[1], 1'b0);
      for (i = 0; i < 8; i = i + 1)
        e[i] = lut[{k[0] ? (i == 0 && k[1]) : d[4*i+3], d[4*i+2 -: 3]}];
      chk({24'h000000, cell_output}, {24'h000000, e});
    end
    setall(cfg(2'h0, 16'h8000, 5'h04));
    for (k = 0; k < 34; k = k + 1) begin
      drv(~(32'h00000001 << k), 1'b0, k != 32);
      chk({31'h0, cascade_out}, {31'h0, k == 33});
    end
    setall(cfg(2'h1, 16'hE896, 5'h00));
    for (k = 0; k < 12; k = k + 1) begin
      a = (k == 0) ? 8'hFF : $urandom;
      b = (k == 0) ? 8'h00 : $urandom;
      d = $urandom;
      for (i = 0; i < 8; i = i + 1)
        d[4*i+1 -: 2] = {b[i], a[i]};
      x = a + b + k[0];
      drv(d, k[0], 1'b1);
      chk({23'h0, carry_out, cell_output}, {23'h0, x});
      acc(1'b0, 6'h24, 32'h00000000);
      chk(r & 32'h0001FFFF, {15'h0, x[8], x[7:0], x[7:0]});
    end
    // cascade low kills every sum, but the carry chain keeps running
    setall(cfg(2'h1, 16'hE896, 5'h04));
    drv(d, 1'b1, 1'b0);
    chk({23'h0, carry_out, cell_output}, {23'h0, x[8], 8'h00});
    acc(1'b1, 6'h28, 32'h00000004);
    chk(r, 32'h00000004);
    setall(cfg(2'h2, 16'hA05A, 5'h1A));
    v = $urandom;
    @(posedge sys_clk) clk_en <= 1'b1;
    for (i = 0; i < 8; i = i + 1)
      d[4*i+3 -: 4] = {3'h6, v[i]};
    drv(d, 1'b0, 1'b1);
    chk({24'h000000, cell_output}, {24'h000000, v});
    @(posedge sys_clk) clk_en <= 1'b0;
    drv(d & 32'h77777777, 1'b0, 1'b1);
    @(posedge sys_clk) clk_en <= 1'b1;
    repeat (5) @(posedge sys_clk);
    clk_en <= 1'b0;
    drv(d & 32'h77777777, 1'b0, 1'b1);
    e = v + 8'h05;
    chk({24'h000000, cell_output}, {24'h000000, e});
    acc(1'b0, 6'h20, 32'h00000000);
    chk(r, {24'h000000, e});
    acc(1'b0, 6'h2C, 32'h00000000);
    chk(r, 32'h0000AAAA);
    chk({31'h0, cascade_out}, 32'h00000001);
    @(posedge sys_clk) clr_n <= 1'b0;
    pre_n <= 1'b0;
    drv(32'h00000000, 1'b0, 1'b1);
    chk({24'h000000, cell_output}, 32'h00000000);
    @(posedge sys_clk) clr_n <= 1'b1;
    drv(32'h00000000, 1'b0, 1'b1);
    chk({24'h000000, cell_output}, 32'h000000FF);
    @(posedge sys_clk) pre_n <= 1'b1;
    setall(cfg(2'h3, 16'hA05A, 5'h02));
    @(posedge sys_clk) clk_en <= 1'b1;
    drv(32'h00000000, 1'b0, 1'b1);
    chk({24'h000000, cell_output}, 32'h00000000);
    summarize;
  end
endmodule // lcm_group_tb

// ---- lcm_nbr.sv ----
`timescale 1ns/1ps
module lcm_nbr (
  input wire sys_clk,
  input wire [31:0] req_data,
  input wire req_cin,
  input wire req_cas,
  output reg [31:0] cell_data,
  output reg carry_in,
  output reg cascade_in
);
  // neighbours are registered, so they only move after an edge
  always @(posedge sys_clk) begin
    cell_data <= req_data;
    carry_in <= req_cin;
    cascade_in <= req_cas;
  end
endmodule // lcm_nbr

// ---- lcm_sync.v ----
`timescale 1ns/1ps
module lcm_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input wire sys_clk,
  input wire resetn,
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout_q
);
  // first stage feeds only the second stage
  reg [WIDTH-1:0] meta_q;

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= RST_VAL;
      dout_q <= RST_VAL;
    end else begin
      meta_q <= din;
      dout_q <= meta_q;
    end
  end
endmodule // lcm_sync
